/* File: logic/ddca_arbiter.sv */
// Dual device command arbiter: host decode, one-entry queue, link hand-off
`include "ddca_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module ddca_arbiter (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Jumper straps, taken once after reset
    input wire logic [15:0] jmp_fl_base,
    input wire logic [15:0] jmp_cr_base,
    input wire logic [15:0] jmp_boot_base,
    input wire logic [2:0] jmp_vec_sel,
    input wire logic [1:0] jmp_level,
    // Host bus access
    input wire logic host_sel,
    input wire logic host_wr,
    input wire logic [15:0] host_addr,
    input wire logic [15:0] host_wdata,
    output logic [15:0] host_rdata,
    output logic host_ack,
    // Host interrupt
    output logic host_irq,
    output logic [8:0] host_vector,
    output logic [1:0] host_level,
    input wire logic host_irq_ack,
    // Link to the storage controller
    output logic ibus_valid,
    output var ddca_pkg::ddca_dev_t ibus_dev,
    output logic [15:0] ibus_word,
    input wire logic ibus_ready,
    input wire logic ibus_done,
    // Device status view
    output logic fl_busy,
    output logic cr_busy
);
    import ddca_pkg::*;

    ddca_state_t s_q;
    ddca_state_t s_d;

    // Window decode; device windows are four bytes wide
    function automatic ddca_hit_t decode(input logic [15:0] a, input logic [15:0] fb,
                                         input logic [15:0] cb, input logic [15:0] bb);
        ddca_hit_t h;
        h = DDCA_HIT_NONE;
        if (a[15:`DDCA_DEV_CMP_LSB] == fb[15:`DDCA_DEV_CMP_LSB]) begin
            h = DDCA_HIT_FL;
        end else if (a[15:`DDCA_DEV_CMP_LSB] == cb[15:`DDCA_DEV_CMP_LSB]) begin
            h = DDCA_HIT_CR;
        end else if (a[15:`DDCA_BOOT_CMP_LSB] == bb[15:`DDCA_BOOT_CMP_LSB]) begin
            h = DDCA_HIT_BOOT;
        end
        return h;
    endfunction

    // Vector lookup table selected by jumpers
    function automatic logic [8:0] vec_lookup(input logic [2:0] sel);
        logic [8:0] v;
        case (sel)
            3'h0: v = 9'h060;
            3'h1: v = 9'h070;
            3'h2: v = 9'h080;
            3'h3: v = 9'h090;
            3'h4: v = 9'h0a0;
            3'h5: v = 9'h0b0;
            3'h6: v = 9'h0c0;
            default: v = 9'h0d0;
        endcase
        return v;
    endfunction

    // Index of the ready/done bit of a device's status word
    function automatic int rdy_bit(input ddca_dev_t d);
        return (d == DDCA_FLOPPY) ? `DDCA_FL_DONE_BIT : `DDCA_CR_RDY_BIT;
    endfunction

    // One-hot mask of a device's ready/done bit
    function automatic logic [15:0] rdy_mask(input ddca_dev_t d);
        return 16'h0001 << rdy_bit(d);
    endfunction

    function automatic logic [1:0] cs_idx(input ddca_dev_t d);
        return (d == DDCA_FLOPPY) ? `DDCA_IDX_FLOPPY_CTRL_STATUS_WORD
                                  : `DDCA_IDX_CARTRIDGE_CTRL_STATUS_WORD;
    endfunction

    ddca_hit_t hit;
    logic [1:0] widx;
    logic is_cmd;
    ddca_dev_t cmd_dev;
    logic fl_ie;
    logic cr_ie;

    // Host access decode, shared by the next-state logic and the checks
    always_comb begin
        hit = decode(host_addr, s_q.fl_base_q, s_q.cr_base_q, s_q.boot_base_q);
        widx = {hit == DDCA_HIT_CR, host_addr[1]};
        cmd_dev = (hit == DDCA_HIT_CR) ? DDCA_CART : DDCA_FLOPPY;
        is_cmd = 1'b0;
        if (host_sel && host_wr && s_q.strap_taken_q && !host_addr[1]) begin
            if (hit == DDCA_HIT_FL) begin
                is_cmd = host_wdata[`DDCA_FL_GO_BIT];
            end else if (hit == DDCA_HIT_CR) begin
                is_cmd = !host_wdata[`DDCA_CR_RDY_BIT];
            end
        end
        fl_ie = s_q.mem_q[`DDCA_IDX_FLOPPY_CTRL_STATUS_WORD][`DDCA_FL_IE_BIT];
        cr_ie = s_q.mem_q[`DDCA_IDX_CARTRIDGE_CTRL_STATUS_WORD][`DDCA_CR_IE_BIT];
    end

    // Next state; completion is handled before a new command so the
    // freshly freed executor can take it in the same cycle
    always_comb begin
        s_d = s_q;
        s_d.host_ack_q = 1'b0;
        // Straps are caught only after reset release
        if (!s_q.strap_taken_q) begin
            s_d.strap_taken_q = 1'b1;
            s_d.fl_base_q = jmp_fl_base;
            s_d.cr_base_q = jmp_cr_base;
            s_d.boot_base_q = jmp_boot_base;
            s_d.vec_sel_q = jmp_vec_sel;
            s_d.level_q = jmp_level;
        end
        s_d.vector_q = vec_lookup(s_q.vec_sel_q);
        // Holding register empties only when the controller takes it
        if (s_q.ib_valid_q && ibus_ready) begin
            s_d.ib_valid_q = 1'b0;
        end
        // Acknowledge first so a same-cycle completion still raises the line
        if (host_irq_ack) begin
            s_d.irq_q = 1'b0;
        end
        if (ibus_done && s_q.busy_q) begin
            s_d.mem_q[cs_idx(s_q.exec_dev_q)][rdy_bit(s_q.exec_dev_q)] = 1'b1;
            if (s_q.exec_dev_q == DDCA_CART ? cr_ie : fl_ie) begin
                s_d.irq_q = 1'b1;
            end
            if (s_q.queue_valid_q) begin
                // Queued command goes out the moment the other one ends
                s_d.exec_dev_q = s_q.queue_dev_q;
                s_d.ib_valid_q = 1'b1;
                s_d.ib_dev_q = s_q.queue_dev_q;
                s_d.ib_word_q = s_q.queue_word_q;
                s_d.queue_valid_q = 1'b0;
            end else begin
                s_d.busy_q = 1'b0;
            end
        end
        // Host access; unmapped addresses get no acknowledge
        if (host_sel && s_q.strap_taken_q && hit != DDCA_HIT_NONE) begin
            s_d.host_ack_q = 1'b1;
            if (host_wr) begin
                if (hit != DDCA_HIT_BOOT) begin
                    // Ready/done bits belong to the arbiter, not to software
                    if (host_addr[1]) begin
                        s_d.mem_q[widx] = host_wdata;
                    end else begin
                        // Merge with s_d, not s_q: a completion landing in the
                        // same cycle as the write must not be lost
                        s_d.mem_q[widx] = (host_wdata & ~rdy_mask(cmd_dev))
                                        | (s_d.mem_q[widx] & rdy_mask(cmd_dev));
                    end
                end
            end else if (hit == DDCA_HIT_BOOT) begin
                s_d.host_rdata_q = `DDCA_BOOT_WORD;
            end else begin
                s_d.host_rdata_q = s_q.mem_q[widx];
            end
        end
        if (is_cmd) begin
            if (!s_d.busy_q) begin
                // Idle: straight to the controller
                s_d.busy_q = 1'b1;
                s_d.exec_dev_q = cmd_dev;
                s_d.ib_valid_q = 1'b1;
                s_d.ib_dev_q = cmd_dev;
                s_d.ib_word_q = host_wdata;
                s_d.mem_q[cs_idx(cmd_dev)][rdy_bit(cmd_dev)] = 1'b0;
            end else if (!s_d.queue_valid_q && s_d.exec_dev_q != cmd_dev) begin
                // Other device busy: park it, both now look busy
                s_d.queue_valid_q = 1'b1;
                s_d.queue_dev_q = cmd_dev;
                s_d.queue_word_q = host_wdata;
                s_d.mem_q[cs_idx(cmd_dev)][rdy_bit(cmd_dev)] = 1'b0;
            end
            // A second command to the busy device is dropped; its bit stays clear
        end
        // Busy views registered so the outputs leave straight from flops;
        // taken from s_d so they move in the same cycle as the status bits
        s_d.fl_busy_q = !s_d.mem_q[`DDCA_IDX_FLOPPY_CTRL_STATUS_WORD][`DDCA_FL_DONE_BIT];
        s_d.cr_busy_q = !s_d.mem_q[`DDCA_IDX_CARTRIDGE_CTRL_STATUS_WORD][`DDCA_CR_RDY_BIT];
    end

    // State register; reset leaves both devices ready
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.mem_q[`DDCA_IDX_FLOPPY_CTRL_STATUS_WORD] <= `DDCA_FL_CS_RST;
            s_q.mem_q[`DDCA_IDX_CARTRIDGE_CTRL_STATUS_WORD] <= `DDCA_CR_CS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state flops
    assign host_rdata = s_q.host_rdata_q;
    assign host_ack = s_q.host_ack_q;
    assign host_irq = s_q.irq_q;
    assign host_vector = s_q.vector_q;
    assign host_level = s_q.level_q;
    assign ibus_valid = s_q.ib_valid_q;
    assign ibus_dev = s_q.ib_dev_q;
    assign ibus_word = s_q.ib_word_q;
    assign fl_busy = s_q.fl_busy_q;
    assign cr_busy = s_q.cr_busy_q;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence fl_running;
        s_q.busy_q && s_q.exec_dev_q == DDCA_FLOPPY;
    endsequence
    sequence cr_running;
        s_q.busy_q && s_q.exec_dev_q == DDCA_CART;
    endsequence
    sequence finish_with_queue;
        ibus_done && s_q.queue_valid_q;
    endsequence
    sequence mapped_access;
        host_sel && s_q.strap_taken_q && hit != DDCA_HIT_NONE;
    endsequence
    sequence dev_read;
        host_sel && !host_wr && s_q.strap_taken_q && (hit == DDCA_HIT_FL || hit == DDCA_HIT_CR);
    endsequence
    sequence boot_read;
        host_sel && !host_wr && s_q.strap_taken_q && hit == DDCA_HIT_BOOT;
    endsequence

    one_exec_a: assert property (s_q.ib_valid_q |-> s_q.busy_q && s_q.ib_dev_q == s_q.exec_dev_q)
        else $error("link word does not belong to executing device");
    fl_start_a: assert property (!s_q.busy_q && is_cmd && cmd_dev == DDCA_FLOPPY |=>
        ibus_valid && ibus_dev == DDCA_FLOPPY && fl_busy)
        else $error("idle floppy command not forwarded");
    cr_queue_a: assert property (fl_running and (!ibus_done && !s_q.queue_valid_q && is_cmd
        && cmd_dev == DDCA_CART) |=> s_q.queue_valid_q && cr_busy && fl_busy)
        else $error("cartridge command not queued");
    // A floppy command in the completion cycle is queued again and clears done
    fl_done_a: assert property (fl_running and finish_with_queue and (!(is_cmd && cmd_dev == DDCA_FLOPPY))
        |=> !fl_busy && ibus_valid && ibus_dev == DDCA_CART)
        else $error("floppy completion did not hand over");
    fl_queue_a: assert property (cr_running and (!ibus_done && !s_q.queue_valid_q && is_cmd
        && cmd_dev == DDCA_FLOPPY) |=> s_q.queue_valid_q && fl_busy)
        else $error("floppy command not queued");
    cr_done_a: assert property (cr_running and (ibus_done && !(is_cmd && cmd_dev == DDCA_CART)) |=> !cr_busy)
        else $error("cartridge ready not set");
    cr_handoff_a: assert property (cr_running and finish_with_queue |=> ibus_valid
        && ibus_dev == DDCA_FLOPPY ##1 s_q.busy_q)
        else $error("queued floppy command lost");
    idle_after_a: assert property (s_q.busy_q && ibus_done && !s_q.queue_valid_q && !is_cmd
        |=> !s_q.busy_q && !fl_busy && !cr_busy)
        else $error("devices not ready after completion");
    rd_hold_a: assert property (!(host_sel && !host_wr && s_q.strap_taken_q && hit != DDCA_HIT_NONE)
        |=> $stable(host_rdata))
        else $error("held read data changed");
    link_hold_a: assert property (ibus_valid && !ibus_ready |=> ibus_valid && $stable(ibus_word))
        else $error("link word dropped before taken");
    irq_raise_a: assert property (cr_running and (ibus_done && cr_ie) |=> host_irq)
        else $error("completion interrupt missing");
    cr_start_a: assert property (!s_q.busy_q && is_cmd && cmd_dev == DDCA_CART |=>
        ibus_valid && ibus_dev == DDCA_CART && cr_busy)
        else $error("idle cartridge command not forwarded");
    vec_map_a: assert property (s_q.strap_taken_q ##1 1'b1 |-> host_vector == vec_lookup(s_q.vec_sel_q))
        else $error("vector not from lookup");

    // Host side: acknowledge only inside the windows, read data from the right word; then interrupt hold and queue device checks
    map_ack_a: assert property (mapped_access |=> host_ack)
        else $error("mapped access not acknowledged");
    unmapped_quiet_a: assert property (host_sel && s_q.strap_taken_q && hit == DDCA_HIT_NONE |=> !host_ack)
        else $error("unmapped access acknowledged");
    rd_word_a: assert property (dev_read |=> host_rdata == $past(s_q.mem_q[widx]))
        else $error("read data not from buffer word");
    boot_rd_a: assert property (boot_read |=> host_rdata == `DDCA_BOOT_WORD)
        else $error("boot read data wrong");
    irq_hold_a: assert property (host_irq && !host_irq_ack |=> host_irq)
        else $error("interrupt dropped before acknowledge");
    queue_other_a: assert property (s_q.queue_valid_q |-> s_q.busy_q && s_q.queue_dev_q != s_q.exec_dev_q)
        else $error("queue holds the executing device");
endmodule

`default_nettype wire

/* File: logic/ddca_consts.svh */
// Constants for the dual device command arbiter
`ifndef DDCA_CONSTS_SVH
`define DDCA_CONSTS_SVH
// Status word bit positions
`define DDCA_FL_GO_BIT 0
`define DDCA_FL_DONE_BIT 5
`define DDCA_FL_IE_BIT 6
`define DDCA_CR_IE_BIT 6
`define DDCA_CR_RDY_BIT 7
// Word indices in the data buffer memory
`define DDCA_IDX_FLOPPY_CTRL_STATUS_WORD 2'h0
`define DDCA_IDX_FLOPPY_DATA_WORD 2'h1
`define DDCA_IDX_CARTRIDGE_CTRL_STATUS_WORD 2'h2
`define DDCA_IDX_CARTRIDGE_ADDR_WORD 2'h3
// Reset values: both devices ready
`define DDCA_FL_CS_RST 16'h0020
`define DDCA_CR_CS_RST 16'h0080
// Host address decode: device window and boot window compare bits
`define DDCA_DEV_CMP_LSB 2
`define DDCA_BOOT_CMP_LSB 9
// Bootstrap word returned (contents not modelled)
`define DDCA_BOOT_WORD 16'h0000
`endif

/* File: logic/ddca_pkg.sv */
// Types for the dual device command arbiter
`default_nettype none

package ddca_pkg;
    typedef enum logic {DDCA_FLOPPY, DDCA_CART} ddca_dev_t;
    typedef enum logic [1:0] {DDCA_HIT_NONE, DDCA_HIT_FL, DDCA_HIT_CR, DDCA_HIT_BOOT} ddca_hit_t;
    typedef struct packed {
        logic strap_taken_q;
        logic [15:0] fl_base_q;
        logic [15:0] cr_base_q;
        logic [15:0] boot_base_q;
        logic [2:0] vec_sel_q;
        logic [1:0] level_q;
        logic [3:0][15:0] mem_q;
        logic busy_q;
        ddca_dev_t exec_dev_q;
        logic queue_valid_q;
        ddca_dev_t queue_dev_q;
        logic [15:0] queue_word_q;
        logic ib_valid_q;
        ddca_dev_t ib_dev_q;
        logic [15:0] ib_word_q;
        logic [15:0] host_rdata_q;
        logic host_ack_q;
        logic irq_q;
        logic [8:0] vector_q;
        logic fl_busy_q;
        logic cr_busy_q;
    } ddca_state_t;
endpackage

`default_nettype wire

/* File: sim/ddca_ctrl_model.sv */
// Storage controller stand-in on the link: takes command words and reports completion
`timescale 1ns/1ns
`default_nettype none

module ddca_ctrl_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Link from the arbiter
    input wire logic ibus_valid,
    input wire ddca_pkg::ddca_dev_t ibus_dev,
    output logic ibus_ready,
    output logic ibus_done,
    // Pacing set by the bench, record read back by it
    input wire logic [7:0] ready_wait,
    input wire logic [7:0] run_wait,
    output var int taken_cnt,
    output var ddca_pkg::ddca_dev_t last_dev
);
    import ddca_pkg::*;

    // One word at a time; done never comes before the word is taken
    initial begin
        ibus_ready = 1'b0;
        ibus_done = 1'b0;
        taken_cnt = 0;
        last_dev = DDCA_FLOPPY;
        forever begin
            @(posedge clk_sys);
            if (!sys_rst && ibus_valid === 1'b1) begin
                repeat (ready_wait) @(posedge clk_sys);
                ibus_ready <= 1'b1;
                @(posedge clk_sys);
                ibus_ready <= 1'b0;
                last_dev <= ibus_dev;
                taken_cnt <= taken_cnt + 1;
                repeat (run_wait) @(posedge clk_sys);
                ibus_done <= 1'b1;
                @(posedge clk_sys);
                ibus_done <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

/* File: sim/dual_device_command_arbiter_test.sv */
// Self-checking bench for the dual device command arbiter
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp, what) begin compares++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH %0t %s", $time, what); end end

module dual_device_command_arbiter_test;
    import ddca_pkg::*;
    localparam logic [15:0] FL_BASE = 16'h1000;
    localparam logic [15:0] CR_BASE = 16'h2000;
    localparam logic [15:0] BOOT_BASE = 16'h4000;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic host_sel = 1'b0, host_wr = 1'b0, host_irq_ack = 1'b0;
    logic [15:0] host_addr = 16'h0000, host_wdata = 16'h0000, host_rdata, rd;
    logic host_ack, host_irq, ibus_valid, ibus_ready, ibus_done, fl_busy, cr_busy, ack;
    logic [1:0] host_level;
    logic [8:0] host_vector;
    logic [15:0] ibus_word;
    logic [7:0] ready_wait = 8'h06, run_wait = 8'h14;
    ddca_dev_t ibus_dev, last_dev;
    int taken_cnt, err_total = 0, compares = 0;

    ddca_arbiter ddca_arbiter_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .jmp_fl_base(FL_BASE),
        .jmp_cr_base(CR_BASE), .jmp_boot_base(BOOT_BASE), .jmp_vec_sel(3'h2), .jmp_level(2'h1),
        .host_sel(host_sel), .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .host_ack(host_ack), .host_irq(host_irq), .host_vector(host_vector),
        .host_level(host_level), .host_irq_ack(host_irq_ack), .ibus_valid(ibus_valid),
        .ibus_dev(ibus_dev), .ibus_word(ibus_word), .ibus_ready(ibus_ready), .ibus_done(ibus_done),
        .fl_busy(fl_busy), .cr_busy(cr_busy));

    ddca_ctrl_model ddca_ctrl_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .ibus_valid(ibus_valid), .ibus_dev(ibus_dev), .ibus_ready(ibus_ready), .ibus_done(ibus_done),
        .ready_wait(ready_wait), .run_wait(run_wait), .taken_cnt(taken_cnt), .last_dev(last_dev));

    // 125 MHz system clock
    initial forever #4 clk_sys = ~clk_sys;

    // Counts, verdict, end of run
    task automatic results;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One host access; ack and read data sampled once the taking edge has landed
    task automatic host_xfer(input logic wr, input logic [15:0] addr, input logic [15:0] wdata);
        @(posedge clk_sys);
        host_sel <= 1'b1;
        host_wr <= wr;
        host_addr <= addr;
        host_wdata <= wdata;
        @(posedge clk_sys);
        host_sel <= 1'b0;
        #1;
        ack = host_ack;
        rd = host_rdata;
    endtask

    // Bounded wait: n > 0 for n words taken, n = 0 for both devices idle
    task automatic wait_for(input int n);
        for (int i = 0; i < 400; i++) begin
            @(posedge clk_sys);
            #1;
            if (n > 0 ? taken_cnt >= n : (fl_busy === 1'b0 && cr_busy === 1'b0)) return;
        end
        err_total++;
        $display("MISMATCH %0t wait ran out", $time);
        results();
    endtask

    // Reset image, window decode, unmapped access, read data holding
    task automatic s_reset;
        `CHK({fl_busy, cr_busy, host_level}, {1'b0, 1'b0, 2'h1}, "idle after reset")
        `CHK(host_vector, 9'h080, "vector from table")
        host_xfer(1'b0, BOOT_BASE + 16'h0010, 16'h0000);
        `CHK({ack, rd}, {1'b1, 16'h0000}, "boot ack")
        host_xfer(1'b0, FL_BASE, 16'h0000);
        `CHK({ack, rd}, {1'b1, 16'h0020}, "fl word")
        host_xfer(1'b0, CR_BASE, 16'h0000);
        `CHK({ack, rd}, {1'b1, 16'h0080}, "cr word")
        host_xfer(1'b1, 16'h0800, 16'hffff);
        `CHK(ack, 1'b0, "unmapped")
        `CHK(rd, 16'h0080, "rdata held")
    endtask

    // Floppy from idle, cartridge queued behind it, cartridge interrupt at the end
    task automatic s_fl_then_cr;
        host_xfer(1'b1, FL_BASE, 16'h0001);
        `CHK({ack, ibus_valid, ibus_dev, fl_busy}, {1'b1, 1'b1, DDCA_FLOPPY, 1'b1}, "fl sent")
        `CHK(ibus_word, 16'h0001, "fl word out")
        host_xfer(1'b1, CR_BASE, 16'h0040);
        `CHK({fl_busy, cr_busy, ibus_dev}, {1'b1, 1'b1, DDCA_FLOPPY}, "cr queued")
        wait_for(2);
        `CHK({last_dev, fl_busy, cr_busy}, {DDCA_CART, 1'b0, 1'b1}, "cr after fl")
        `CHK(ibus_word, 16'h0040, "cr word out")
        wait_for(0);
        `CHK(host_irq, 1'b1, "cr irq")
        host_xfer(1'b0, CR_BASE, 16'h0000);
        `CHK(rd[7], 1'b1, "cr ready")
        @(posedge clk_sys);
        host_irq_ack <= 1'b1;
        @(posedge clk_sys);
        host_irq_ack <= 1'b0;
        #1;
        `CHK(host_irq, 1'b0, "irq cleared")
    endtask

    // Cartridge from idle with a prompt controller, floppy queued, repeat floppy dropped
    task automatic s_cr_then_fl;
        ready_wait = 8'h00;
        host_xfer(1'b1, CR_BASE, 16'h0000);
        `CHK({ibus_valid, ibus_dev, cr_busy, fl_busy}, {1'b1, DDCA_CART, 1'b1, 1'b0}, "cr sent")
        host_xfer(1'b1, FL_BASE, 16'h0001);
        `CHK({fl_busy, cr_busy}, 2'b11, "fl queued")
        host_xfer(1'b1, FL_BASE, 16'h0001);
        wait_for(4);
        `CHK({last_dev, cr_busy, fl_busy}, {DDCA_FLOPPY, 1'b0, 1'b1}, "fl after cr")
        wait_for(0);
        repeat (40) @(posedge clk_sys);
        #1;
        `CHK({taken_cnt, host_irq, fl_busy, cr_busy}, {32'd4, 3'b000}, "one per command")
    endtask

    // Reset for 12 cycles, then the scenarios in turn
    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        s_reset();
        s_fl_then_cr();
        s_cr_then_fl();
        results();
    end
endmodule

`default_nettype wire
